// ==== design/uib_pkg.sv ====
package uib_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned EP_N   = 4;
  localparam int unsigned CORE_W = 9;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EP_EVENT_STATUS   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CORE_EVENT_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_EP_EVENT_FORCE    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CORE_EVENT_FORCE  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_EP_EVENT_ACK      = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CORE_EVENT_ACK    = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_EP_ENABLE_STATUS  = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_CORE_ENABLE_STATUS= 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_EP_ENABLE_SET     = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_CORE_ENABLE_SET   = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_EP_ENABLE_CLEAR   = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_CORE_ENABLE_CLEAR = 12'h02c;
  localparam logic [ADDR_W-1:0] OFS_EP_EVENT_GATED    = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_CORE_EVENT_GATED  = 12'h034;

  // ---------------------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned      EP_RX_LSB  = 9;
  localparam int unsigned      EP_TX_LSB  = 1;
  localparam int unsigned      EP0_BIT    = 0;
  localparam logic [REG_W-1:0] EP_VALID   = 16'h1e1f;
  localparam logic [CORE_W-1:0] CORE_VALID = 9'h1ff;
  localparam logic [REG_W-1:0] REG_RESET  = 16'h0000;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [EP_N-1:0]   rx;
    logic [EP_N-1:0]   tx;
    logic              ep0_combined_event;
    logic [CORE_W-1:0] core;
  } uib_evt_type;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        strb;
  } uib_apb_req_type;

  typedef struct packed {
    logic              ready;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } uib_apb_rsp_type;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_EP_EVENT_STATUS,
    SEL_CORE_EVENT_STATUS,
    SEL_EP_EVENT_FORCE,
    SEL_CORE_EVENT_FORCE,
    SEL_EP_EVENT_ACK,
    SEL_CORE_EVENT_ACK,
    SEL_EP_ENABLE_STATUS,
    SEL_CORE_ENABLE_STATUS,
    SEL_EP_ENABLE_SET,
    SEL_CORE_ENABLE_SET,
    SEL_EP_ENABLE_CLEAR,
    SEL_CORE_ENABLE_CLEAR,
    SEL_EP_EVENT_GATED,
    SEL_CORE_EVENT_GATED
  } uib_sel_type;

endpackage : uib_pkg

// ==== design/uib_flag_bank.sv ====
`timescale 1ns/100ps
module uib_flag_bank #(
  parameter int unsigned     W     = 16,
  parameter logic [W-1:0]    VALID = '1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // set and clear strobes, one cycle each
  input  wire logic [W-1:0] i_hw_set,
  input  wire logic [W-1:0] i_sw_set,
  input  wire logic [W-1:0] i_sw_clr,
  input  wire logic [W-1:0] i_en_set,
  input  wire logic [W-1:0] i_en_clr,
  // state
  output logic      [W-1:0] o_flag,
  output logic      [W-1:0] o_enable,
  output logic      [W-1:0] o_gated,
  output logic              o_any_next
);

  logic [W-1:0] flag;
  logic [W-1:0] enable;
  logic [W-1:0] next_flag;
  logic [W-1:0] next_enable;

  // ---------------------------------------------------------------------------
  // per-bit next state
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (VALID[i]) begin : g_live
      // raw flag ignores the mask entirely; a hardware set beats a clear
      always_comb begin
        next_flag[i]   = i_hw_set[i] | i_sw_set[i] | (flag[i] & ~i_sw_clr[i]); // RQ12 RQ22
        next_enable[i] = i_en_set[i] | (enable[i] & ~i_en_clr[i]);
      end
    end else begin : g_dead
      // reserved positions never hold state
      always_comb begin
        next_flag[i]   = 1'b0; // RQ20
        next_enable[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag   <= '0;
      enable <= '0;
    end else begin
      flag   <= next_flag;
      enable <= next_enable;
    end
  end

  assign o_flag     = flag;
  assign o_enable   = enable;
  assign o_gated    = flag & enable; // RQ19
  assign o_any_next = |(next_flag & next_enable);

endmodule : uib_flag_bank

// ==== design/uib_apb_slave.sv ====
`timescale 1ns/100ps
module uib_apb_slave (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // bus side
  input  wire uib_pkg::uib_apb_req_type i_req,
  output uib_pkg::uib_apb_rsp_type      o_rsp,
  // register side
  input  wire logic [31:0]              i_rdata,
  input  wire logic                     i_hit,
  output logic                          o_wr_en
);

  logic [31:0] rdata;
  logic        err;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        setup;
  logic        access;

  assign setup  = i_req.sel & ~i_req.enable;
  assign access = i_req.sel & i_req.enable;

  // ---------------------------------------------------------------------------
  // answer captured in the setup cycle
  // ---------------------------------------------------------------------------
  // zero wait states: the answer is latched at the setup edge so that
  // prdata comes from a flop; the cost is that a hardware event landing
  // in the access cycle only shows on the next read
  always_comb begin
    next_rdata = rdata;
    next_err   = err;
    if (setup) begin
      next_rdata = (i_hit && !i_req.write) ? i_rdata : 32'h0000_0000;
      next_err   = ~i_hit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata <= 32'h0000_0000;
      err   <= 1'b0;
    end else begin
      rdata <= next_rdata;
      err   <= next_err;
    end
  end

  assign o_rsp.ready  = 1'b1;
  assign o_rsp.rdata  = rdata;
  assign o_rsp.slverr = err & access;
  assign o_wr_en      = access & i_req.write & i_hit;

endmodule : uib_apb_slave

// ==== design/uib_irq_bank.sv ====
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// (RQ1) rx flags ep4..ep1 in bits 12..9
// (RQ2) tx flags ep4..ep1 bits 4..1, 8..5 zero
// (RQ3) bit 0 flags ep0 rx or tx
// (RQ4) nine core flags in bits 8..0
// (RQ5) writing one to endpoint force sets flag
// (RQ6) writing one to core force sets flag
// (RQ7) force registers read back source status
// (RQ8) writing one to endpoint ack clears flag
// (RQ9) writing one to core ack clears flag
// (RQ10) ack registers read back source status
// (RQ11) enable status read-only, reset zero, aligned
// (RQ12) masks never gate the raw flags
// (RQ13) endpoint enable set writes set enables
// (RQ14) core enable set writes set enables
// (RQ15) enables set singly, read enable status
// (RQ16) endpoint enable clear writes clear enables
// (RQ17) core enable clear writes clear enables
// (RQ18) enables cleared singly, read enable status
// (RQ19) gated status is flag AND enable
// (RQ20) zero bits and reserved bits change nothing
// (RQ21) interrupt high while any gated bit set
// (RQ22) hardware event beats same-cycle clear
module uib_irq_bank (
  // clock and reset
  input  wire logic                       I_CLK_SYS,
  input  wire logic                       I_RST,
  // apb slave
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [uib_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [uib_pkg::DATA_W-1:0] I_PWDATA,
  input  wire logic [3:0]                 I_PSTRB,
  output logic                            O_PREADY,
  output logic      [uib_pkg::DATA_W-1:0] O_PRDATA,
  output logic                            O_PSLVERR,
  // event pulses from the usb core, same clock
  input  wire logic [uib_pkg::EP_N-1:0]   I_EP_RX_EVENT,
  input  wire logic [uib_pkg::EP_N-1:0]   I_EP_TX_EVENT,
  input  wire logic                       I_EP0_COMBINED_EVENT,
  input  wire logic [uib_pkg::CORE_W-1:0] I_CORE_EVENT,
  // interrupt request
  output logic                            O_IRQ
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  uib_pkg::uib_apb_req_type         req;
  uib_pkg::uib_apb_rsp_type         rsp;
  uib_pkg::uib_evt_type             evt;
  uib_pkg::uib_sel_type             sel;

  // strobes
  logic [uib_pkg::REG_W-1:0]        ep_hw_set;
  logic [uib_pkg::REG_W-1:0]        wdata_lanes;
  logic [uib_pkg::REG_W-1:0]        ep_sw_set;
  logic [uib_pkg::REG_W-1:0]        ep_sw_clr;
  logic [uib_pkg::REG_W-1:0]        ep_en_set;
  logic [uib_pkg::REG_W-1:0]        ep_en_clr;

  logic [uib_pkg::CORE_W-1:0]       core_sw_set;
  logic [uib_pkg::CORE_W-1:0]       core_sw_clr;
  logic [uib_pkg::CORE_W-1:0]       core_en_set;
  logic [uib_pkg::CORE_W-1:0]       core_en_clr;

  // bank state
  logic [uib_pkg::REG_W-1:0]        ep_flag;
  logic [uib_pkg::REG_W-1:0]        ep_enable;
  logic [uib_pkg::REG_W-1:0]        ep_gated;
  logic [uib_pkg::CORE_W-1:0]       core_flag;
  logic [uib_pkg::CORE_W-1:0]       core_enable;
  logic [uib_pkg::CORE_W-1:0]       core_gated;

  logic [uib_pkg::REG_W-1:0]        ep_status;
  logic [uib_pkg::REG_W-1:0]        core_status;
  logic [uib_pkg::REG_W-1:0]        ep_en_status;
  logic [uib_pkg::REG_W-1:0]        core_en_status;
  logic [uib_pkg::REG_W-1:0]        ep_gated_status;
  logic [uib_pkg::REG_W-1:0]        core_gated_status;

  // bus path
  logic                             ep_any_next;
  logic                             core_any_next;
  logic                             wr_en;
  logic                             hit;
  logic [uib_pkg::REG_W-1:0]        rd_reg;
  logic [uib_pkg::DATA_W-1:0]       rd_word;
  logic                             irq;
  logic                             next_irq;

  // ---------------------------------------------------------------------------
  // bus carriers
  // ---------------------------------------------------------------------------
  always_comb begin
    req.sel    = I_PSEL;
    req.enable = I_PENABLE;
    req.write  = I_PWRITE;
    req.addr   = I_PADDR;
    req.wdata  = I_PWDATA;
    req.strb   = I_PSTRB;
  end

  assign O_PREADY  = rsp.ready;
  assign O_PRDATA  = rsp.rdata;
  assign O_PSLVERR = rsp.slverr;

  // ---------------------------------------------------------------------------
  // event mapping
  // ---------------------------------------------------------------------------
  // same clock as the core: no synchroniser
  always_comb begin
    evt.rx                 = I_EP_RX_EVENT;
    evt.tx                 = I_EP_TX_EVENT;
    evt.ep0_combined_event = I_EP0_COMBINED_EVENT;
    evt.core               = I_CORE_EVENT;
  end

  // endpoint word: rx in 12..9, nothing in 8..5, tx in 4..1, ep0 in 0
  always_comb begin
    ep_hw_set = uib_pkg::REG_RESET;
    ep_hw_set[uib_pkg::EP_RX_LSB +: uib_pkg::EP_N] = evt.rx; // RQ1
    ep_hw_set[uib_pkg::EP_TX_LSB +: uib_pkg::EP_N] = evt.tx; // RQ2
    ep_hw_set[uib_pkg::EP0_BIT]                    = evt.ep0_combined_event; // RQ3
  end

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  // exact match: misaligned offsets miss
  always_comb begin
    unique case (req.addr)
      uib_pkg::OFS_EP_EVENT_STATUS:    sel = uib_pkg::SEL_EP_EVENT_STATUS;
      uib_pkg::OFS_CORE_EVENT_STATUS:  sel = uib_pkg::SEL_CORE_EVENT_STATUS;

      uib_pkg::OFS_EP_EVENT_FORCE:     sel = uib_pkg::SEL_EP_EVENT_FORCE;
      uib_pkg::OFS_CORE_EVENT_FORCE:   sel = uib_pkg::SEL_CORE_EVENT_FORCE;

      uib_pkg::OFS_EP_EVENT_ACK:       sel = uib_pkg::SEL_EP_EVENT_ACK;
      uib_pkg::OFS_CORE_EVENT_ACK:     sel = uib_pkg::SEL_CORE_EVENT_ACK;

      uib_pkg::OFS_EP_ENABLE_STATUS:   sel = uib_pkg::SEL_EP_ENABLE_STATUS;
      uib_pkg::OFS_CORE_ENABLE_STATUS: sel = uib_pkg::SEL_CORE_ENABLE_STATUS;

      uib_pkg::OFS_EP_ENABLE_SET:      sel = uib_pkg::SEL_EP_ENABLE_SET;
      uib_pkg::OFS_CORE_ENABLE_SET:    sel = uib_pkg::SEL_CORE_ENABLE_SET;

      uib_pkg::OFS_EP_ENABLE_CLEAR:    sel = uib_pkg::SEL_EP_ENABLE_CLEAR;
      uib_pkg::OFS_CORE_ENABLE_CLEAR:  sel = uib_pkg::SEL_CORE_ENABLE_CLEAR;

      uib_pkg::OFS_EP_EVENT_GATED:     sel = uib_pkg::SEL_EP_EVENT_GATED;
      uib_pkg::OFS_CORE_EVENT_GATED:   sel = uib_pkg::SEL_CORE_EVENT_GATED;
      default:                         sel = uib_pkg::SEL_NONE;
    endcase
  end

  assign hit = (sel != uib_pkg::SEL_NONE);

  // ---------------------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------------------
  // only the two low byte lanes carry register bits; a lane whose strobe
  // is low writes zeros, which by write-one semantics changes nothing
  always_comb begin
    wdata_lanes = req.wdata[uib_pkg::REG_W-1:0];
    if (!req.strb[0]) begin
      wdata_lanes[7:0] = 8'h00;
    end
    if (!req.strb[1]) begin
      wdata_lanes[15:8] = 8'h00;
    end
  end

  always_comb begin
    ep_sw_set   = '0;
    ep_sw_clr   = '0;
    ep_en_set   = '0;
    ep_en_clr   = '0;

    core_sw_set = '0;
    core_sw_clr = '0;
    core_en_set = '0;
    core_en_clr = '0;
    if (wr_en) begin
      unique case (sel)
        // source flags
        uib_pkg::SEL_EP_EVENT_FORCE: begin
          ep_sw_set = wdata_lanes & uib_pkg::EP_VALID; // RQ5 RQ20
        end

        uib_pkg::SEL_CORE_EVENT_FORCE: begin
          core_sw_set = wdata_lanes[uib_pkg::CORE_W-1:0]; // RQ6
        end

        uib_pkg::SEL_EP_EVENT_ACK: begin
          ep_sw_clr = wdata_lanes & uib_pkg::EP_VALID; // RQ8 RQ20
        end

        uib_pkg::SEL_CORE_EVENT_ACK: begin
          core_sw_clr = wdata_lanes[uib_pkg::CORE_W-1:0]; // RQ9
        end

        // enables
        uib_pkg::SEL_EP_ENABLE_SET: begin
          ep_en_set = wdata_lanes & uib_pkg::EP_VALID; // RQ13 RQ15
        end

        uib_pkg::SEL_CORE_ENABLE_SET: begin
          core_en_set = wdata_lanes[uib_pkg::CORE_W-1:0]; // RQ14 RQ15
        end

        uib_pkg::SEL_EP_ENABLE_CLEAR: begin
          ep_en_clr = wdata_lanes & uib_pkg::EP_VALID; // RQ16 RQ18
        end

        uib_pkg::SEL_CORE_ENABLE_CLEAR: begin
          core_en_clr = wdata_lanes[uib_pkg::CORE_W-1:0]; // RQ17 RQ18
        end

        // writes to status and gated registers are accepted and dropped
        default: begin
          ep_sw_set = '0; // RQ11
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // flag banks
  // ---------------------------------------------------------------------------
  // bits 15..13 and 8..5 hold no state
  uib_flag_bank #(
    .W     (uib_pkg::REG_W),
    .VALID (uib_pkg::EP_VALID)
  ) u_ep_bank (
    .i_clk      (I_CLK_SYS),
    .i_rst      (I_RST),
    .i_hw_set   (ep_hw_set),
    .i_sw_set   (ep_sw_set),
    .i_sw_clr   (ep_sw_clr),
    .i_en_set   (ep_en_set),
    .i_en_clr   (ep_en_clr),
    .o_flag     (ep_flag),
    .o_enable   (ep_enable),
    .o_gated    (ep_gated),
    .o_any_next (ep_any_next)
  );

  uib_flag_bank #(
    .W     (uib_pkg::CORE_W),
    .VALID (uib_pkg::CORE_VALID)
  ) u_core_bank (
    .i_clk      (I_CLK_SYS),
    .i_rst      (I_RST),
    .i_hw_set   (evt.core), // RQ4
    .i_sw_set   (core_sw_set),
    .i_sw_clr   (core_sw_clr),
    .i_en_set   (core_en_set),
    .i_en_clr   (core_en_clr),
    .o_flag     (core_flag),
    .o_enable   (core_enable),
    .o_gated    (core_gated),
    .o_any_next (core_any_next)
  );

  // ---------------------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------------------
  assign ep_status         = ep_flag; // RQ1 RQ2 RQ3
  assign core_status       = {7'h00, core_flag}; // RQ4

  assign ep_en_status      = ep_enable; // RQ11
  assign core_en_status    = {7'h00, core_enable}; // RQ11

  assign ep_gated_status   = ep_gated; // RQ19
  assign core_gated_status = {7'h00, core_gated}; // RQ19

  always_comb begin
    unique case (sel)
      uib_pkg::SEL_EP_EVENT_STATUS:    rd_reg = ep_status;
      uib_pkg::SEL_CORE_EVENT_STATUS:  rd_reg = core_status;

      // force and ack show raw flags
      uib_pkg::SEL_EP_EVENT_FORCE:     rd_reg = ep_status; // RQ7
      uib_pkg::SEL_CORE_EVENT_FORCE:   rd_reg = core_status; // RQ7

      uib_pkg::SEL_EP_EVENT_ACK:       rd_reg = ep_status; // RQ10
      uib_pkg::SEL_CORE_EVENT_ACK:     rd_reg = core_status; // RQ10

      uib_pkg::SEL_EP_ENABLE_STATUS:   rd_reg = ep_en_status;
      uib_pkg::SEL_CORE_ENABLE_STATUS: rd_reg = core_en_status;

      uib_pkg::SEL_EP_ENABLE_SET:      rd_reg = ep_en_status; // RQ15
      uib_pkg::SEL_CORE_ENABLE_SET:    rd_reg = core_en_status; // RQ15

      uib_pkg::SEL_EP_ENABLE_CLEAR:    rd_reg = ep_en_status; // RQ18
      uib_pkg::SEL_CORE_ENABLE_CLEAR:  rd_reg = core_en_status; // RQ18

      uib_pkg::SEL_EP_EVENT_GATED:     rd_reg = ep_gated_status;
      uib_pkg::SEL_CORE_EVENT_GATED:   rd_reg = core_gated_status;
      default:                         rd_reg = uib_pkg::REG_RESET;
    endcase
  end

  // upper bus half reads zero
  assign rd_word = {16'h0000, rd_reg};

  // ---------------------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------------------
  // pready tied high: two-cycle transfers
  uib_apb_slave u_apb (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_req   (req),
    .o_rsp   (rsp),
    .i_rdata (rd_word),
    .i_hit   (hit),
    .o_wr_en (wr_en)
  );

  // ---------------------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------------------
  // built from the banks' next values so the line rises and falls on the
  // same edge as the gated flags, with no extra cycle of lag
  always_comb begin
    next_irq = ep_any_next | core_any_next; // RQ21
  end

  // reset drops the line with the banks
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  assign O_IRQ = irq;

endmodule : uib_irq_bank

// ==== verification/uib_irq_bank_chk.sv ====
`timescale 1ns/100ps
module uib_irq_bank_chk (
  // clock and reset
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST,
  // apb
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PSLVERR,
  // events and request
  input wire logic [3:0]  I_EP_RX_EVENT,
  input wire logic [3:0]  I_EP_TX_EVENT,
  input wire logic        I_EP0_COMBINED_EVENT,
  input wire logic [8:0]  I_CORE_EVENT,
  input wire logic        O_IRQ
);
  logic acc;
  logic rdacc;
  logic evt;
  logic bad;
  logic gat;
  assign acc   = I_PSEL && I_PENABLE;
  assign rdacc = acc && !I_PWRITE;
  assign evt   = |{I_EP_RX_EVENT, I_EP_TX_EVENT, I_EP0_COMBINED_EVENT, I_CORE_EVENT};
  assign bad   = (I_PADDR[1:0] != 2'h0) || (I_PADDR > 12'h034);
  assign gat   = (I_PADDR == 12'h030) || (I_PADDR == 12'h034);

  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  rsv_zero_a: assert property (
    rdacc && !bad |-> (I_PADDR[2] ? O_PRDATA[31:9] == 23'h0
                                  : (O_PRDATA[31:13] == 19'h0 && O_PRDATA[8:5] == 4'h0)))
    else $error("reserved read bits set");
  rst_quiet_a: assert property (
    $fell(I_RST) |-> !O_IRQ && O_PRDATA == 32'h0) else $error("state not cleared by reset");
  irq_stable_a: assert property (
    !evt && !(acc && I_PWRITE) |=> $stable(O_IRQ)) else $error("request moved without cause");
  irq_keep_a: assert property (
    evt && !(acc && I_PWRITE) |=> !$fell(O_IRQ)) else $error("request fell on an event");
  gated_zero_a: assert property (
    rdacc && gat && !$past(O_IRQ) |-> O_PRDATA[15:0] == 16'h0) else $error("gated set, no request");
  gated_irq_a: assert property (
    rdacc && gat && O_PRDATA[15:0] != 16'h0 |-> $past(O_IRQ)) else $error("gated bit, no request");
  err_map_a: assert property (
    O_PSLVERR == (acc && bad)) else $error("error response wrong");
  rdata_hold_a: assert property (
    acc |=> $stable(O_PRDATA)) else $error("read data moved after access");

  cover property ($rose(O_IRQ));
  cover property (acc && bad);
  cover property (rdacc && gat && O_PRDATA != 32'h0);
endmodule : uib_irq_bank_chk

bind uib_irq_bank uib_irq_bank_chk chk_u (.I_CLK_SYS, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .O_PRDATA, .O_PSLVERR, .I_EP_RX_EVENT, .I_EP_TX_EVENT, .I_EP0_COMBINED_EVENT,
  .I_CORE_EVENT, .O_IRQ);

// ==== verification/uib_evt_src.sv ====
`timescale 1ns/100ps
module uib_evt_src (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // request from the bench
  input  wire logic                 i_fire,
  input  wire uib_pkg::uib_evt_type i_evt,
  // event pulses to the bank
  output uib_pkg::uib_evt_type      o_evt
);
  uib_pkg::uib_evt_type next_evt;
  // pulses only: a held level would re-set an acked flag every cycle
  always_comb begin
    next_evt = i_fire ? i_evt : '0;
  end
  always_ff @(posedge i_clk) begin
    o_evt <= i_rst ? '0 : next_evt;
  end
endmodule : uib_evt_src

// ==== verification/uib_irq_bank_tb_top.sv ====
`timescale 1ns/100ps
module uib_irq_bank_tb_top;
  // ---------------------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------------------
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 pen = 1'b0;
  logic                 pwr = 1'b0;
  logic [11:0]          paddr = 12'h0;
  logic [31:0]          pwdata = 32'h0;
  logic [3:0]           pstrb = 4'hf;
  logic                 pready;
  logic [31:0]          prdata;
  logic                 pslverr;
  logic                 irq;
  logic                 fire = 1'b0;
  uib_pkg::uib_evt_type fevt = '0;
  uib_pkg::uib_evt_type ev;
  int                   err_total = 0;
  int                   n_tests = 0;

  always #20 clk = ~clk;

  uib_evt_src src_u (.i_clk(clk), .i_rst(rst), .i_fire(fire), .i_evt(fevt), .o_evt(ev));

  uib_irq_bank dut_u (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_EP_RX_EVENT(ev.rx), .I_EP_TX_EVENT(ev.tx),
    .I_EP0_COMBINED_EVENT(ev.ep0_combined_event), .I_CORE_EVENT(ev.core), .O_IRQ(irq));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // race raises an event that lands on the access edge of this transfer;
  // an idle cycle follows so that psel is never driven twice in one step
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic race, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {16'h0, d};
    fire   <= race;
    @(posedge clk);
    pen  <= 1'b1;
    fire <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      err_total++;
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, 1'b0, q, e);
  endtask : wr

  task automatic rd(input string nm, input logic [11:0] a, input logic [15:0] x);
    logic [31:0] q;
    logic        e;
    bus(1'b0, a, 16'h0, 1'b0, q, e);
    chk(nm, {16'h0, x}, q);
    chk({nm, " err"}, 32'h0, {31'h0, e});
  endtask : rd

  task automatic pulse(input uib_pkg::uib_evt_type v);
    fevt <= v;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    for (int a = 0; a <= 'h34; a += 4) begin
      rd("reset value", a[11:0], 16'h0);
    end
    wr(12'h018, 16'hffff);
    rd("read-only enables", 12'h018, 16'h0);
    bus(1'b0, 12'h038, 16'h0, 1'b0, q, e);
    chk("unmapped data", 32'h0, q);
    chk("unmapped err", 32'h1, {31'h0, e});
    pstrb <= 4'h2;
    wr(12'h008, 16'h1e1f);
    pstrb <= 4'hf;
    rd("lane 0 off", 12'h000, 16'h1e00);
  endtask : t_reset

  task automatic t_events;
    pulse('1);
    rd("ep status", 12'h000, 16'h1e1f);
    rd("core status", 12'h004, 16'h01ff);
    rd("ep gated", 12'h030, 16'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask : t_events

  task automatic t_ack;
    wr(12'h010, 16'h0201);
    rd("ep ack read", 12'h010, 16'h1c1e);
    wr(12'h014, 16'h0000);
    rd("core zero ack", 12'h004, 16'h01ff);
    wr(12'h014, 16'h01fe);
    rd("core ack read", 12'h014, 16'h0001);
    wr(12'h010, 16'hffff);
    wr(12'h014, 16'hffff);
    rd("ep cleared", 12'h000, 16'h0);
    wr(12'h008, 16'hffff);
    rd("ep force read", 12'h008, 16'h1e1f);
    wr(12'h00c, 16'h0100);
    rd("core force read", 12'h00c, 16'h0100);
  endtask : t_ack

  task automatic t_mask;
    wr(12'h020, 16'h0200);
    rd("ep enable set read", 12'h020, 16'h0200);
    rd("ep gated one", 12'h030, 16'h0200);
    chk("irq ep", 32'h1, {31'h0, irq});
    wr(12'h024, 16'h0100);
    rd("core enables", 12'h01c, 16'h0100);
    rd("core gated", 12'h034, 16'h0100);
    wr(12'h028, 16'h0200);
    rd("ep enable clear read", 12'h028, 16'h0);
    chk("irq core only", 32'h1, {31'h0, irq});
    wr(12'h02c, 16'h0100);
    rd("core enable clear read", 12'h02c, 16'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    rd("raw kept", 12'h000, 16'h1e1f);
  endtask : t_mask

  task automatic t_race;
    logic [31:0] q;
    logic        e;
    fevt <= 18'h00100;
    bus(1'b1, 12'h014, 16'h0100, 1'b1, q, e);
    rd("event beats ack", 12'h004, 16'h0100);
    wr(12'h014, 16'h0100);
    rd("core acked", 12'h004, 16'h0);
  endtask : t_race

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_events();
    t_ack();
    t_mask();
    t_race();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("status after reset", 12'h000, 16'h0);
    stop_test();
  end
endmodule : uib_irq_bank_tb_top
